// ===== inc/stack_call_pkg.sv
// constants, operation codes and carrier structs of the stack and call unit
// assumes a byte-wide stack memory answering one access per acknowledge
// ****************************************************************
// Notes on behaviour
// ****************************************************************
package stack_call_pkg;

	// ****************************************************************
	// widths and reset values
	// ****************************************************************
	localparam logic [23:0] SP_RST      = 24'h000000;
	localparam logic [23:0] UUP_RST     = 24'h000000;
	localparam logic [23:0] WIDE_RST    = 24'h000000;
	localparam logic [19:0] PC_RST      = 20'h00000;
	localparam logic [15:0] PSW_RST     = 16'h0000;
	localparam int          IE_BIT      = 5;

	// ****************************************************************
	// stack steps and fixed addresses
	// ****************************************************************
	localparam logic [23:0] STEP_ONE    = 24'h000001;
	localparam logic [23:0] STEP_WORD   = 24'h000002;
	localparam logic [23:0] STEP_WIDE   = 24'h000003;
	localparam logic [23:0] STEP_TRAP   = 24'h000004;
	localparam logic [2:0]  NB_BYTE     = 3'h1;
	localparam logic [2:0]  NB_WORD     = 3'h2;
	localparam logic [2:0]  NB_WIDE     = 3'h3;
	localparam logic [2:0]  NB_TRAP     = 3'h4;
	localparam logic [2:0]  FIXED_PAGE_CALL_LEN   = 3'h2;
	localparam logic [2:0]  TABLE_CALL_LEN   = 3'h1;
	localparam logic [2:0]  TRAP_LEN    = 3'h1;
	localparam logic [4:0]  PAGE_HI     = 5'h01;
	localparam logic [9:0]  TABLE_HI    = 10'h001;
	localparam logic [23:0] TRAP_VECTOR = 24'h00003E;
	localparam logic [3:0]  PSW_SLOT    = 4'h5;
	localparam logic [3:0]  LIST_END    = 4'h8;

	// ****************************************************************
	// operations and carriers
	// ****************************************************************
	typedef enum logic [4:0] {
		OP_POP_PSW, OP_POP_SFRP, OP_POP_SFR, OP_POP_WIDE, OP_POP_LIST,
		OP_USER_RESTORE, OP_SET_UUP,
		OP_MOVE_SP_IMM, OP_MOVE_SP_PAIR, OP_MOVE_PAIR_SP,
		OP_PTR_ADD, OP_PTR_SUB, OP_PTR_INC, OP_PTR_DEC,
		OP_CALL_FAR, OP_CALL_BASE, OP_CALL_PAIR, OP_CALL_PAIR_IND,
		OP_CALL_FIXED_PAGE, OP_CALL_TABLE, OP_TRAP
	} op_e;

	typedef struct packed {
		logic        valid;
		op_e         op;
		logic [23:0] imm;
		logic [7:0]  mask;
		logic [2:0]  pairIdx;
		logic [2:0]  insnLen;
		logic [19:0] insnPc;
	} cmd_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} memReq_s;

	typedef struct packed {
		logic        valid;
		logic        isByte;
		logic [7:0]  addr;
		logic [15:0] data;
	} sfrWr_s;

endpackage : stack_call_pkg

// ===== rtl/pair_file.sv
// eight 16-bit general register pairs, one write port, two read ports
// assumes writer and readers share the core clock; read data registered
`timescale 1ns/1ps
module pair_file (
	// clock
	input  wire logic        mclk,
	// write port
	input  wire logic        wrEn,
	input  wire logic [2:0]  wrIdx,
	input  wire logic [15:0] wrData,
	// read ports
	input  wire logic [2:0]  rdIdxA,
	input  wire logic [2:0]  rdIdxB,
	output logic      [15:0] rdDataA,
	output logic      [15:0] rdDataB
);
	typedef struct packed {
		logic [7:0][15:0] word;
		logic [15:0]      rdA;
		logic [15:0]      rdB;
	} pf_s;

	pf_s cur_ff;
	pf_s nxt_ff;

	// ****************************************************************
	// per-entry write and registered reads
	// ****************************************************************
	for (genvar i = 0; i < 8; i++) begin : g_entry
		always_comb begin
			nxt_ff.word[i] = (wrEn && wrIdx == 3'(i)) ? wrData
			                                          : cur_ff.word[i];
		end
	end

	always_comb begin
		nxt_ff.rdA = cur_ff.word[rdIdxA];
		nxt_ff.rdB = cur_ff.word[rdIdxB];
	end

	always_ff @(posedge mclk) begin
		cur_ff <= nxt_ff;
	end

	assign rdDataA = cur_ff.rdA;
	assign rdDataB = cur_ff.rdB;

endmodule : pair_file

// ===== rtl/stack_call_unit.sv
// stack restore, pointer arithmetic, calls and software trap execution
// assumes byte memory: request held until memAck, read data valid with ack
`timescale 1ns/1ps
module stack_call_unit
	import stack_call_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  srst,
	// command
	input  wire stack_call_pkg::cmd_s  cmd,
	output logic                       cmdReady,
	output logic                       cmdDone,
	// stack memory
	output stack_call_pkg::memReq_s    mem,
	input  wire logic                  memAck,
	input  wire logic [7:0]            memRdata,
	// special function register writes
	output stack_call_pkg::sfrWr_s     sfrWr,
	// architectural state
	output logic      [23:0]           sp,
	output logic      [23:0]           userStackPointer,
	output logic      [23:0]           thirdExtendedPair,
	output logic      [19:0]           pc,
	output logic      [15:0]           statusWord,
	// pair inspection
	input  wire logic [2:0]            pairPeekIdx,
	output logic      [15:0]           pairPeekData
);
	import stack_call_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_FETCH, S_LIST, S_WRITE, S_READ
	} state_e;

	typedef struct packed {
		state_e      st;
		op_e         op;
		logic [23:0] sp;
		logic [23:0] user_stack_pointer;
		logic [23:0] wide;
		logic [19:0] pc;
		logic [15:0] status_word;
		logic [7:0]  mask;
		logic [3:0]  listIdx;
		logic [2:0]  pairIdx;
		logic [2:0]  cnt;
		logic [2:0]  nBytes;
		logic [23:0] base;
		logic [31:0] wbuf;
		logic [23:0] rbuf;
		logic [19:0] target;
		logic [23:0] rdAddr;
		logic        needRead;
		logic        ready;
		logic        done;
		memReq_s     mem;
		sfrWr_s      sfr;
	} unit_s;

	unit_s       cur_ff;
	unit_s       nxt_ff;
	logic        pairWe;
	logic [2:0]  pairWrIdx;
	logic [15:0] pairWrData;
	logic [15:0] pairRd;
	logic [23:0] merged;
	logic [19:0] retAddr;

	pair_file u_pairs (
		.mclk    (mclk),
		.wrEn    (pairWe),
		.wrIdx   (pairWrIdx),
		.wrData  (pairWrData),
		.rdIdxA  (cur_ff.pairIdx),
		.rdIdxB  (pairPeekIdx),
		.rdDataA (pairRd),
		.rdDataB (pairPeekData)
	);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		nxt_ff.sfr.valid = 1'b0;
		pairWe = 1'b0;
		pairWrIdx = cur_ff.listIdx[2:0];
		pairWrData = 16'h0000;
		merged = cur_ff.rbuf;
		merged[{cur_ff.cnt[1:0], 3'b000} +: 8] = memRdata;
		retAddr = cmd.insnPc + 20'(cmd.insnLen);
		unique case (cur_ff.st)
			S_IDLE: begin
				if (cmd.valid) begin
					nxt_ff.ready = 1'b0;
					nxt_ff.op = cmd.op;
					nxt_ff.mask = cmd.mask;
					nxt_ff.pairIdx = cmd.pairIdx;
					nxt_ff.listIdx = 4'h0;
					nxt_ff.cnt = 3'h0;
					nxt_ff.rbuf = 24'h000000;
					nxt_ff.needRead = 1'b0;
					nxt_ff.st = S_IDLE;
					case (cmd.op)
						OP_POP_PSW, OP_POP_SFRP, OP_POP_SFR, OP_POP_WIDE: begin
							nxt_ff.st = S_READ;
							nxt_ff.base = cur_ff.sp;
							nxt_ff.mem = '{1'b1, 1'b0, cur_ff.sp, 8'h00};
							nxt_ff.nBytes = (cmd.op == OP_POP_SFR) ? NB_BYTE
							              : (cmd.op == OP_POP_WIDE) ? NB_WIDE
							              : NB_WORD;
						end
						OP_POP_LIST, OP_USER_RESTORE: nxt_ff.st = S_LIST;
						OP_SET_UUP:      nxt_ff.user_stack_pointer = cmd.imm;
						OP_MOVE_SP_IMM:  nxt_ff.sp = cmd.imm;
						OP_MOVE_SP_PAIR: nxt_ff.sp = cur_ff.wide;
						OP_MOVE_PAIR_SP: nxt_ff.wide = cur_ff.sp;
						OP_PTR_ADD:
							nxt_ff.sp = cur_ff.sp + {8'h00, cmd.imm[15:0]};
						OP_PTR_SUB:
							nxt_ff.sp = cur_ff.sp - {8'h00, cmd.imm[15:0]};
						OP_PTR_INC: nxt_ff.sp = cur_ff.sp + STEP_ONE;
						OP_PTR_DEC: nxt_ff.sp = cur_ff.sp - STEP_ONE;
						OP_CALL_PAIR, OP_CALL_PAIR_IND: nxt_ff.st = S_FETCH;
						OP_CALL_FAR, OP_CALL_BASE, OP_CALL_FIXED_PAGE,
						OP_CALL_TABLE: begin
							nxt_ff.st = S_WRITE;
							nxt_ff.nBytes = NB_WIDE;
							nxt_ff.base = cur_ff.sp - STEP_WIDE;
							nxt_ff.sp = cur_ff.sp - STEP_WIDE;
							nxt_ff.target = cmd.imm[19:0];
							if (cmd.op == OP_CALL_BASE)
								nxt_ff.target = {4'h0, cmd.imm[15:0]};
							if (cmd.op == OP_CALL_FIXED_PAGE) begin
								retAddr = cmd.insnPc + 20'(FIXED_PAGE_CALL_LEN);
								nxt_ff.target = {4'h0, PAGE_HI, cmd.imm[10:0]};
							end
							if (cmd.op == OP_CALL_TABLE) begin
								retAddr = cmd.insnPc + 20'(TABLE_CALL_LEN);
								nxt_ff.needRead = 1'b1;
								nxt_ff.rdAddr = {8'h00, TABLE_HI, cmd.imm[4:0],
								                 1'b0};
							end
							nxt_ff.wbuf = {8'h00, 4'h0, retAddr};
							nxt_ff.mem = '{1'b1, 1'b1, cur_ff.sp - STEP_WIDE,
							               retAddr[7:0]};
						end
						OP_TRAP: begin
							retAddr = cmd.insnPc + 20'(TRAP_LEN);
							nxt_ff.st = S_WRITE;
							nxt_ff.nBytes = NB_TRAP;
							nxt_ff.base = cur_ff.sp - STEP_TRAP;
							nxt_ff.sp = cur_ff.sp - STEP_TRAP;
							nxt_ff.wbuf = {cur_ff.status_word, retAddr[15:0]};
							nxt_ff.status_word[IE_BIT] = 1'b0;
							nxt_ff.needRead = 1'b1;
							nxt_ff.rdAddr = TRAP_VECTOR;
							nxt_ff.mem = '{1'b1, 1'b1, cur_ff.sp - STEP_TRAP,
							               retAddr[7:0]};
						end
						default: nxt_ff.st = S_IDLE;
					endcase
					if (nxt_ff.st == S_IDLE) begin
						nxt_ff.ready = 1'b1;
						nxt_ff.done = 1'b1;
					end
				end
			end
			S_FETCH: begin
				nxt_ff.cnt = 3'h1;
				if (cur_ff.cnt != 3'h0) begin
					nxt_ff.cnt = 3'h0;
					nxt_ff.st = S_WRITE;
					nxt_ff.nBytes = NB_WIDE;
					nxt_ff.base = cur_ff.sp - STEP_WIDE;
					nxt_ff.sp = cur_ff.sp - STEP_WIDE;
					nxt_ff.wbuf = {8'h00, 4'h0, retAddr};
					nxt_ff.target = {4'h0, pairRd};
					nxt_ff.needRead = (cur_ff.op == OP_CALL_PAIR_IND);
					nxt_ff.rdAddr = {8'h00, pairRd};
					nxt_ff.mem = '{1'b1, 1'b1, cur_ff.sp - STEP_WIDE,
					               retAddr[7:0]};
				end
			end
			S_LIST: begin
				nxt_ff.listIdx = cur_ff.listIdx + 4'h1;
				if (cur_ff.listIdx == LIST_END) begin
					nxt_ff.st = S_IDLE;
					nxt_ff.ready = 1'b1;
					nxt_ff.done = 1'b1;
				end else if (cur_ff.mask[cur_ff.listIdx[2:0]]) begin
					nxt_ff.listIdx = cur_ff.listIdx;
					nxt_ff.st = S_READ;
					nxt_ff.cnt = 3'h0;
					nxt_ff.nBytes = NB_WORD;
					nxt_ff.base = (cur_ff.op == OP_USER_RESTORE) ? cur_ff.user_stack_pointer
					                                            : cur_ff.sp;
					nxt_ff.mem = '{1'b1, 1'b0, nxt_ff.base, 8'h00};
				end
			end
			S_WRITE: begin
				if (memAck) begin
					nxt_ff.cnt = cur_ff.cnt + 3'h1;
					nxt_ff.mem.addr = cur_ff.base + 24'(nxt_ff.cnt);
					nxt_ff.mem.wdata = cur_ff.wbuf[{nxt_ff.cnt[1:0], 3'b000} +: 8];
					if (nxt_ff.cnt == cur_ff.nBytes) begin
						nxt_ff.cnt = 3'h0;
						nxt_ff.mem.req = 1'b0;
						nxt_ff.mem.we = 1'b0;
						if (cur_ff.needRead) begin
							nxt_ff.st = S_READ;
							nxt_ff.nBytes = NB_WORD;
							nxt_ff.base = cur_ff.rdAddr;
							nxt_ff.rbuf = 24'h000000;
							nxt_ff.mem = '{1'b1, 1'b0, cur_ff.rdAddr, 8'h00};
						end else begin
							nxt_ff.pc = cur_ff.target;
							nxt_ff.st = S_IDLE;
							nxt_ff.ready = 1'b1;
							nxt_ff.done = 1'b1;
						end
					end
				end
			end
			S_READ: begin
				if (memAck) begin
					nxt_ff.rbuf = merged;
					nxt_ff.cnt = cur_ff.cnt + 3'h1;
					nxt_ff.mem.addr = cur_ff.base + 24'(nxt_ff.cnt);
					if (nxt_ff.cnt == cur_ff.nBytes) begin
						nxt_ff.cnt = 3'h0;
						nxt_ff.mem.req = 1'b0;
						nxt_ff.st = S_IDLE;
						nxt_ff.ready = 1'b1;
						nxt_ff.done = 1'b1;
						case (cur_ff.op)
							OP_POP_PSW: nxt_ff.status_word = merged[15:0];
							OP_POP_SFRP, OP_POP_SFR:
								nxt_ff.sfr = '{1'b1, cur_ff.op == OP_POP_SFR,
								               cmd.imm[7:0], merged[15:0]};
							OP_POP_WIDE: nxt_ff.wide = merged;
							OP_POP_LIST, OP_USER_RESTORE: begin
								nxt_ff.st = S_LIST;
								nxt_ff.ready = 1'b0;
								nxt_ff.done = 1'b0;
								nxt_ff.listIdx = cur_ff.listIdx + 4'h1;
								if (cur_ff.op == OP_USER_RESTORE) begin
									nxt_ff.user_stack_pointer = cur_ff.user_stack_pointer + STEP_WORD;
									if (cur_ff.listIdx == PSW_SLOT)
										nxt_ff.status_word = merged[15:0];
									else
										pairWe = 1'b1;
								end else begin
									nxt_ff.sp = cur_ff.sp + STEP_WORD;
									pairWe = 1'b1;
								end
								pairWrData = merged[15:0];
							end
							default: nxt_ff.pc = {4'h0, merged[15:0]};
						endcase
						if (cur_ff.op == OP_POP_PSW || cur_ff.op == OP_POP_SFRP
						    || cur_ff.op == OP_POP_SFR || cur_ff.op == OP_POP_WIDE)
							nxt_ff.sp = cur_ff.sp + 24'(cur_ff.nBytes);
					end
				end
			end
			default: nxt_ff.st = S_IDLE;
		endcase
		if (srst) begin
			nxt_ff = '0;
			nxt_ff.st = S_IDLE;
			nxt_ff.op = OP_POP_PSW;
			nxt_ff.sp = SP_RST;
			nxt_ff.user_stack_pointer = UUP_RST;
			nxt_ff.wide = WIDE_RST;
			nxt_ff.pc = PC_RST;
			nxt_ff.status_word = PSW_RST;
			nxt_ff.ready = 1'b1;
			pairWe = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		cur_ff <= nxt_ff;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign cmdReady          = cur_ff.ready;
	assign cmdDone           = cur_ff.done;
	assign mem               = cur_ff.mem;
	assign sfrWr             = cur_ff.sfr;
	assign sp                = cur_ff.sp;
	assign userStackPointer  = cur_ff.user_stack_pointer;
	assign thirdExtendedPair = cur_ff.wide;
	assign pc                = cur_ff.pc;
	assign statusWord        = cur_ff.status_word;

endmodule : stack_call_unit

// ===== sim/stack_call_unit_asserts.sv
// port checker for the stack and call unit
// assumes bound onto every stack_call_unit instance
`timescale 1ns/1ps
module stack_call_unit_asserts
	import stack_call_pkg::*;
(
	// clock and reset
	input wire logic                    mclk,
	input wire logic                    srst,
	// command
	input wire stack_call_pkg::cmd_s    cmd,
	input wire logic                    cmdReady,
	input wire logic                    cmdDone,
	// memory
	input wire stack_call_pkg::memReq_s mem,
	input wire logic                    memAck,
	// state
	input wire logic [23:0]             sp,
	input wire logic [23:0]             thirdExtendedPair,
	input wire logic [15:0]             statusWord
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	logic        take;
	logic [23:0] immZx;
	logic [23:0] immFull;
	logic [23:0] memAddr;
	assign take = cmd.valid && cmdReady;
	assign immZx = {8'h00, cmd.imm[15:0]};
	assign immFull = cmd.imm;
	assign memAddr = mem.addr;
	a_ptr_inc: assert property (take && cmd.op == OP_PTR_INC
		|=> cmdDone && sp == $past(sp) + 24'h1) else $error("inc step");
	a_ptr_dec: assert property (take && cmd.op == OP_PTR_DEC
		|=> cmdDone && sp == $past(sp) - 24'h1) else $error("dec step");
	a_ptr_add: assert property (take && cmd.op == OP_PTR_ADD
		|=> sp == $past(sp) + $past(immZx)) else $error("add imm");
	a_ptr_sub: assert property (take && cmd.op == OP_PTR_SUB
		|=> sp == $past(sp) - $past(immZx)) else $error("sub imm");
	a_move_imm: assert property (take && cmd.op == OP_MOVE_SP_IMM
		|=> sp == $past(immFull)) else $error("move imm");
	a_pair_copy: assert property (take && cmd.op == OP_MOVE_PAIR_SP
		|=> thirdExtendedPair == $past(sp)) else $error("pair copy");
	a_flags_kept: assert property (take && cmd.op inside
		{OP_PTR_ADD, OP_PTR_SUB, OP_PTR_INC, OP_PTR_DEC, OP_MOVE_SP_IMM}
		|=> $stable(statusWord)) else $error("flags moved");
	a_call_push: assert property (take && cmd.op == OP_CALL_FAR
		|=> mem.req && mem.we && memAddr == $past(sp) - 24'h3)
		else $error("call push");
	a_trap_frame: assert property (take && cmd.op == OP_TRAP
		|=> memAddr == $past(sp) - 24'h4 && sp == $past(sp) - 24'h4)
		else $error("trap frame");
	a_req_hold: assert property (mem.req && !memAck
		|=> mem.req && $stable(memAddr)) else $error("request dropped");
	a_done_bound: assert property (take
		|-> ##[1:200] cmdDone) else $error("no completion");
endmodule : stack_call_unit_asserts

bind stack_call_unit stack_call_unit_asserts chk_u (.mclk(mclk),
	.srst(srst), .cmd(cmd), .cmdReady(cmdReady), .cmdDone(cmdDone),
	.mem(mem), .memAck(memAck), .sp(sp),
	.thirdExtendedPair(thirdExtendedPair), .statusWord(statusWord));

// ===== sim/stack_call_unit_tb_top.sv
// self-checking bench for the stack and call unit
// assumes the package, memory model and checker are compiled first
`timescale 1ns/1ps
module stack_call_unit_tb_top;
	import stack_call_pkg::*;
	// ****
	// harness
	// ****
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        slow = 1'b0;
	cmd_s        cmd = '0;
	logic [2:0]  pairPeekIdx = 3'h0;
	memReq_s     mem;
	logic        memAck, cmdReady, cmdDone;
	logic [7:0]  memRdata;
	logic [23:0] sp, user_stack_pointer, wide;
	logic [19:0] pc;
	logic [15:0] status_word, peek;
	sfrWr_s      sfr;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	always #10 mclk = ~mclk;
	stack_call_unit dut_u (.mclk(mclk), .srst(srst), .cmd(cmd),
		.cmdReady(cmdReady), .cmdDone(cmdDone), .mem(mem), .memAck(memAck),
		.memRdata(memRdata), .sfrWr(sfr), .sp(sp), .userStackPointer(user_stack_pointer),
		.thirdExtendedPair(wide), .pc(pc), .statusWord(status_word),
		.pairPeekIdx(pairPeekIdx), .pairPeekData(peek));
	stack_mem_model mem_u (.mclk(mclk), .mem(mem), .slow(slow),
		.memAck(memAck), .memRdata(memRdata));
	task automatic check(input string what, input logic [23:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic run(input op_e op, input logic [23:0] imm,
		input logic [7:0] msk = 8'h00, input logic [19:0] ipc = 20'h0,
		input logic [2:0] len = 3'h0);
		int n;
		n = 0;
		cmd <= '{1'b1, op, imm, msk, 3'h0, len, ipc};
		@(posedge mclk);
		cmd.valid <= 1'b0;
		@(posedge mclk);
		while (cmdDone !== 1'b1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		check("done", {23'h0, cmdDone}, 24'h1);
	endtask : run
	task automatic poke(input logic [23:0] a, input logic [7:0] b[$]);
		foreach (b[i]) mem_u.store[a + 24'(i)] = b[i];
	endtask : poke
	task automatic peek_bytes(input logic [23:0] a, input logic [7:0] b[$]);
		foreach (b[i])
			check("byte", {16'h0, mem_u.store[a + 24'(i)]}, {16'h0, b[i]});
	endtask : peek_bytes
	task automatic pair_is(input logic [2:0] idx, input logic [15:0] exp);
		pairPeekIdx <= idx;
		repeat (2) @(posedge mclk);
		check("pair", {8'h0, peek}, {8'h0, exp});
	endtask : pair_is
	// ****
	// scenarios
	// ****
	task automatic t_restore();
		run(OP_MOVE_SP_IMM, 24'h001000);
		poke(24'h001000, {8'hA5, 8'hC3, 8'h56, 8'h34, 8'h12, 8'h9A, 8'h78,
		                  8'hBC});
		run(OP_POP_PSW, 24'h0);
		check("psw", {8'h0, status_word}, 24'h00C3A5);
		check("sp", sp, 24'h001002);
		run(OP_POP_WIDE, 24'h0);
		check("wide", wide, 24'h123456);
		check("sp", sp, 24'h001005);
		check("psw", {8'h0, status_word}, 24'h00C3A5);
		run(OP_POP_SFR, 24'h0000F0);
		check("sfr", {sfr.addr, sfr.data}, 24'hF0009A);
		check("sfrv", {22'h0, sfr.valid, sfr.isByte}, 24'h3);
		check("sp", sp, 24'h001006);
		run(OP_POP_SFRP, 24'h0000F2);
		check("sfr", {sfr.addr, sfr.data}, 24'hF2BC78);
		check("sfrv", {22'h0, sfr.valid, sfr.isByte}, 24'h2);
		check("sp", sp, 24'h001008);
	endtask : t_restore
	task automatic t_lists();
		slow <= 1'b1;
		run(OP_MOVE_SP_IMM, 24'h002000);
		poke(24'h002000, {8'h01, 8'hA0, 8'h02, 8'hB0, 8'h03, 8'hC0});
		run(OP_POP_LIST, 24'h0, 8'hA1);
		check("sp", sp, 24'h002006);
		pair_is(3'h0, 16'hA001);
		pair_is(3'h5, 16'hB002);
		pair_is(3'h7, 16'hC003);
		run(OP_SET_UUP, 24'h003000);
		poke(24'h003000, {8'h44, 8'h33, 8'h66, 8'h55});
		run(OP_USER_RESTORE, 24'h0, 8'h22);
		check("uup", user_stack_pointer, 24'h003004);
		pair_is(3'h1, 16'h3344);
		check("psw", {8'h0, status_word}, 24'h005566);
		slow <= 1'b0;
	endtask : t_lists
	task automatic t_pointer();
		run(OP_MOVE_SP_IMM, 24'hFFFFFE);
		run(OP_PTR_INC, 24'h0);
		run(OP_PTR_INC, 24'h0);
		check("sp", sp, 24'h000000);
		run(OP_PTR_DEC, 24'h0);
		check("sp", sp, 24'hFFFFFF);
		run(OP_PTR_ADD, 24'hABFFFF);
		check("sp", sp, 24'h00FFFE);
		run(OP_PTR_SUB, 24'hCD0050);
		check("sp", sp, 24'h00FFAE);
		run(OP_MOVE_PAIR_SP, 24'h0);
		check("wide", wide, 24'h00FFAE);
		run(OP_MOVE_SP_IMM, 24'h000010);
		run(OP_PTR_SUB, 24'h000020);
		check("sp", sp, 24'hFFFFF0);
		run(OP_MOVE_SP_PAIR, 24'h0);
		check("sp", sp, 24'h00FFAE);
		check("psw", {8'h0, status_word}, 24'h005566);
	endtask : t_pointer
	task automatic t_calls();
		run(OP_MOVE_SP_IMM, 24'h008000);
		run(OP_CALL_FAR, 24'hF12345, 8'h0, 20'h5FFFE, 3'h4);
		check("pc", {4'h0, pc}, 24'h012345);
		check("sp", sp, 24'h007FFD);
		peek_bytes(24'h007FFD, {8'h02, 8'h00, 8'h06});
		run(OP_CALL_BASE, 24'h03ABCD, 8'h0, 20'h00100, 3'h3);
		check("pc", {4'h0, pc}, 24'h00ABCD);
		run(OP_CALL_FIXED_PAGE, 24'hFFFFFF, 8'h0, 20'h00200, 3'h2);
		check("pc", {4'h0, pc}, 24'h000FFF);
		peek_bytes(24'h007FF7, {8'h02, 8'h02, 8'h00});
		poke(24'h00007E, {8'hCD, 8'h9B});
		run(OP_CALL_TABLE, 24'h00001F, 8'h0, 20'h4FFFF, 3'h1);
		check("pc", {4'h0, pc}, 24'h009BCD);
		peek_bytes(24'h007FF4, {8'h00, 8'h00, 8'h05});
		check("sp", sp, 24'h007FF4);
		run(OP_CALL_PAIR, 24'h0, 8'h0, 20'h01000, 3'h2);
		check("pc", {4'h0, pc}, 24'h00A001);
		peek_bytes(24'h007FF1, {8'h02, 8'h10, 8'h00});
		poke(24'h00A001, {8'h34, 8'h12});
		run(OP_CALL_PAIR_IND, 24'h0, 8'h0, 20'h01000, 3'h2);
		check("pc", {4'h0, pc}, 24'h001234);
		check("sp", sp, 24'h007FEE);
		check("psw", {8'h0, status_word}, 24'h005566);
	endtask : t_calls
	task automatic t_trap();
		run(OP_MOVE_SP_IMM, 24'h009000);
		poke(24'h00003E, {8'h78, 8'h56});
		run(OP_TRAP, 24'h0, 8'h0, 20'h41234, 3'h1);
		check("pc", {4'h0, pc}, 24'h005678);
		check("sp", sp, 24'h008FFC);
		check("psw", {8'h0, status_word}, 24'h005546);
		peek_bytes(24'h008FFC, {8'h35, 8'h12, 8'h66, 8'h55});
	endtask : t_trap
	task automatic report_and_stop();
		if (num_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		check("reset", {22'h0, cmdReady, cmdDone}, 24'h2);
		check("sp", sp, SP_RST);
		check("psw", {8'h0, status_word}, {8'h0, PSW_RST});
		t_restore();
		t_lists();
		t_pointer();
		t_calls();
		t_trap();
		report_and_stop();
	end
endmodule : stack_call_unit_tb_top

// ===== sim/stack_mem_model.sv
// byte-wide stack memory answering the unit, one ack per byte
// assumes requests held until ack; slow adds two wait cycles
`timescale 1ns/1ps
module stack_mem_model
	import stack_call_pkg::*;
(
	// clock
	input  wire logic                    mclk,
	// request side
	input  wire stack_call_pkg::memReq_s mem,
	input  wire logic                    slow,
	// answer side
	output logic                         memAck,
	output logic [7:0]                   memRdata
);
	// ****
	// storage and answer
	// ****
	logic [7:0] store [logic [23:0]];
	logic [1:0] waitCnt = 2'h0;
	initial memAck = 1'b0;
	initial memRdata = 8'hA5;
	always @(posedge mclk) begin
		if (mem.req && !memAck && (!slow || waitCnt == 2'h2)) begin
			memAck <= 1'b1;
			if (mem.we)
				store[mem.addr] = mem.wdata;
			memRdata <= store.exists(mem.addr) ? store[mem.addr] : 8'h00;
			waitCnt <= 2'h0;
		end else begin
			memAck <= 1'b0;
			memRdata <= ~memRdata;
			waitCnt <= (mem.req && !memAck) ? waitCnt + 2'h1 : 2'h0;
		end
	end
endmodule : stack_mem_model
